// >>> common/flash_ctl_pkg.sv
// Constants and types shared by the flash protect and mode controller.
// Summary of operation
// [R1] Security-enable register holds one read/write bit at bit 0; upper bits zero.
// [R2] Security-enable bit is reset only by power-on reset.
// [R3] Protect status register shows four read-only block protect bits in bits 3-0.
// [R4] Programming or erasing a block whose effective protection is set is refused.
// [R5] Protect status bits follow the stored nonvolatile protection state.
// [R6] Protect mask bits 3-0: writing 0 releases protection, 1 keeps it.
// [R7] System reset sets all four protect mask bits to 1.
// [R8] Software must not change mask bits during program or erase.
// [R9] Software reads the mask register back before touching the array.
// [R10] Software issues every command cycle as a full 32-bit store.
// [R11] After the last command cycle the operation runs without bus accesses.
// [R12] Page program, chip erase and block erase; protection acts per block.
// [R13] Software waits 200 us after ready before reading the array.
// [R14] Read mode after any reset and after normal completion; reads only then.
// [R15] Command from read mode enters automatic mode; normal end returns to read.
// [R16] No array reads or fetches while an automatic operation runs.
// [R17] Read/reset command or hardware reset forces read mode after abnormal end.
// [R18] Software runs the routine from RAM with no interrupts or faults.
// [R19] Unused bits of the three registers read zero and ignore writes.
// [R20] Ready flag reads 0 while busy or after failure, 1 after normal end.
// [R21] Mask and security writes need the unlock key within 16 clocks before.
// [R22] Security is active when security bit and all four protect bits are 1.
// [R23] A command cycle out of order abandons the command and returns to read.
package flash_ctl_pkg;

    // ==========================================================================
    // Register map and reset values
    localparam logic [7:0]  SEC_OFS     = 8'h10;
    localparam logic [7:0]  FSTAT_OFS   = 8'h20;
    localparam logic [7:0]  PSTAT_OFS   = 8'h30;
    localparam logic [7:0]  PMASK_OFS   = 8'h38;
    localparam logic [31:0] UNLOCK_KEY  = 32'hA74A9D23;
    localparam logic [4:0]  WINDOW_CLKS = 5'h10;
    localparam logic        SEC_RST     = 1'b1;
    localparam logic [3:0]  MASK_RST    = 4'hF;

    // ==========================================================================
    // Command cycles on the flash store port
    localparam logic [15:0] CMD_ADDR_A = 16'h5400;
    localparam logic [15:0] CMD_ADDR_B = 16'hAA00;
    localparam logic [7:0]  CD_AA      = 8'hAA;
    localparam logic [7:0]  CD_55      = 8'h55;
    localparam logic [7:0]  CD_PROG    = 8'hA0;
    localparam logic [7:0]  CD_ERASE   = 8'h80;
    localparam logic [7:0]  CD_CHIP    = 8'h10;
    localparam logic [7:0]  CD_BLOCK   = 8'h30;
    localparam logic [7:0]  CD_RESET   = 8'hF0;
    localparam logic [1:0]  PAGE_LAST  = 2'h3;
    localparam int          BLK_LSB    = 14;

    typedef enum logic [1:0] {OP_PROG, OP_CHIP, OP_BLOCK} op_kind_t;
    typedef enum logic [3:0] {
        ST_READ, ST_C1, ST_C2, ST_PAGE, ST_E3, ST_E4, ST_E5, ST_BUSY, ST_LOCK
    } seq_state_t;

endpackage

// >>> common/unlock_if.sv
// Interface between the register file and one unlock-key window gate.
`timescale 1ns/100ps
`default_nettype none
interface unlock_if;
    logic        wr_stb;
    logic [31:0] wr_data;
    logic        accept;
    modport ctl  (output wr_stb, output wr_data, input accept);
    modport gate (input wr_stb, input wr_data, output accept);
endinterface
`default_nettype wire

// >>> hw/key_window_gate.sv
// Unlock-key window that qualifies a data write to one protected register.
`timescale 1ns/100ps
`default_nettype none
module key_window_gate import flash_ctl_pkg::*; (
    input wire logic mclk_i,
    input wire logic resetn_i,
    unlock_if.gate   port
);
    logic [4:0] cnt_ff;
    logic [4:0] nxt_cnt;
    logic       open_w;

    // A key write arms the window; any other full-word write to the same register disarms it.
    assign open_w      = (cnt_ff != 5'h00) && (cnt_ff <= WINDOW_CLKS);
    assign port.accept = port.wr_stb && (port.wr_data != UNLOCK_KEY) && open_w; // [R21]

    always_comb begin
        nxt_cnt = 5'h00;
        if (port.wr_stb) begin
            nxt_cnt = (port.wr_data == UNLOCK_KEY) ? 5'h01 : 5'h00; // [R21]
        end else if (open_w) begin
            nxt_cnt = cnt_ff + 5'h01;
        end
    end

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cnt_ff <= 5'h00;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end

    chk_window_closed: assert property (@(posedge mclk_i) disable iff (!resetn_i) // [R21]
        (cnt_ff > WINDOW_CLKS || cnt_ff == 5'h00) |-> !port.accept)
        else $error("Protected write accepted outside the key window.");

    chk_key_arms: assert property (@(posedge mclk_i) disable iff (!resetn_i) // [R21]
        (port.wr_stb && port.wr_data == UNLOCK_KEY)
        ##1 (!port.wr_stb) [*8] ##1 (!port.wr_stb) [*7]
        |=> (cnt_ff == WINDOW_CLKS))
        else $error("Key window does not span sixteen clocks.");
endmodule
`default_nettype wire

// >>> hw/flash_protect_and_mode_control.sv
// Flash protect, security and command sequencer with an Avalon-MM register slave.
//
// Our own choices: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/100ps
`default_nettype none
module flash_protect_and_mode_control import flash_ctl_pkg::*; (
    input  wire logic        mclk_i,
    input  wire logic        resetn_i,
    input  wire logic        power_on_resetn_i,
    input  wire logic [7:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    input  wire logic [3:0]  avs_byteenable_i,
    output logic      [31:0] avs_readdata_o,
    output logic             avs_waitrequest_o,
    input  wire logic        cmd_wr_i,
    input  wire logic [15:0] cmd_addr_i,
    input  wire logic [31:0] cmd_data_i,
    input  wire logic [3:0]  nv_protect_i,
    input  wire logic        op_done_i,
    input  wire logic        op_fail_i,
    output logic             read_mode_o,
    output logic             ready_busy_flag_o,
    output logic             op_start_o,
    output var op_kind_t     op_kind_o,
    output logic      [3:0]  op_blocks_o,
    output logic             prog_we_o,
    output logic      [15:0] prog_addr_o,
    output logic      [31:0] prog_data_o
);

    // ==========================================================================
    // Decoding helpers
    function automatic logic is_cyc(input logic [15:0] a, input logic [31:0] d,
                                    input logic [15:0] ea, input logic [7:0] ed);
        is_cyc = (a == ea) && (d == {24'h000000, ed});
    endfunction

    function automatic logic [1:0] blk_of(input logic [15:0] a);
        blk_of = a[BLK_LSB+1:BLK_LSB];
    endfunction

    // ==========================================================================
    // Bus slave: one wait state, answer stands at the edge where wait is low
    logic        wait_ff;
    logic        nxt_wait;
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;
    logic        sec_ff;
    logic [3:0]  mask_ff;
    logic [3:0]  nxt_mask;
    logic [3:0]  pstat_ff;
    logic        rdy_ff;
    logic        wr_full;

    assign wr_full = avs_write_i && !wait_ff && (avs_byteenable_i == 4'hF); // [R10]

    always_comb begin
        nxt_wait  = 1'b1;
        nxt_rdata = rdata_ff;
        if ((avs_read_i || avs_write_i) && wait_ff) begin
            nxt_wait = 1'b0;
            case (avs_address_i)
                SEC_OFS:   nxt_rdata = {31'h00000000, sec_ff};   // [R1] [R19]
                FSTAT_OFS: nxt_rdata = {31'h00000000, rdy_ff};   // [R20]
                PSTAT_OFS: nxt_rdata = {28'h0000000, pstat_ff};  // [R3] [R19]
                PMASK_OFS: nxt_rdata = {28'h0000000, mask_ff};   // [R6] [R19]
                default:   nxt_rdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wait_ff  <= 1'b1;
            rdata_ff <= 32'h00000000;
        end else begin
            wait_ff  <= nxt_wait;
            rdata_ff <= nxt_rdata;
        end
    end

    // ==========================================================================
    // Key-protected registers
    unlock_if ul_if [2] ();

    assign ul_if[0].wr_stb  = wr_full && (avs_address_i == SEC_OFS);
    assign ul_if[0].wr_data = avs_writedata_i;
    assign ul_if[1].wr_stb  = wr_full && (avs_address_i == PMASK_OFS);
    assign ul_if[1].wr_data = avs_writedata_i;

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : gen_gate
            key_window_gate u_gate (
                .mclk_i   (mclk_i),
                .resetn_i (resetn_i),
                .port     (ul_if[g])
            );
        end
    endgenerate

    always_comb begin
        nxt_mask = mask_ff;
        if (ul_if[1].accept) begin
            nxt_mask = avs_writedata_i[3:0]; // [R6] [R21]
        end
    end

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            mask_ff  <= MASK_RST; // [R7]
            pstat_ff <= 4'h0;
        end else begin
            mask_ff  <= nxt_mask;
            pstat_ff <= nv_protect_i; // [R5]
        end
    end

    // Only the power-on reset touches the security bit.
    always_ff @(posedge mclk_i or negedge power_on_resetn_i) begin
        if (!power_on_resetn_i) begin
            sec_ff <= SEC_RST; // [R2]
        end else if (ul_if[0].accept) begin
            sec_ff <= avs_writedata_i[0]; // [R1] [R21]
        end
    end

    // ==========================================================================
    // Command sequencer
    seq_state_t  state_ff;
    seq_state_t  nxt_state;
    logic [1:0]  wcnt_ff;
    logic [1:0]  nxt_wcnt;
    logic [1:0]  blk_ff;
    logic [1:0]  nxt_blk;
    logic        nxt_rdy;
    logic        start_ff;
    logic        nxt_start;
    op_kind_t    kind_ff;
    op_kind_t    nxt_kind;
    logic [3:0]  blocks_ff;
    logic [3:0]  nxt_blocks;
    logic        we_ff;
    logic        nxt_we;
    logic [15:0] paddr_ff;
    logic [15:0] nxt_paddr;
    logic [31:0] pdata_ff;
    logic [31:0] nxt_pdata;
    logic        rmode_ff;
    logic [3:0]  eff_prot;
    logic        sec_active;
    logic [1:0]  cblk;

    assign eff_prot   = pstat_ff & mask_ff;          // [R6] [R12]
    assign sec_active = sec_ff && (&pstat_ff);       // [R22]
    assign cblk       = blk_of(cmd_addr_i);

    always_comb begin
        nxt_state  = state_ff;
        nxt_wcnt   = wcnt_ff;
        nxt_blk    = blk_ff;
        nxt_rdy    = rdy_ff;
        nxt_start  = 1'b0;
        nxt_kind   = kind_ff;
        nxt_blocks = blocks_ff;
        nxt_we     = 1'b0;
        nxt_paddr  = paddr_ff;
        nxt_pdata  = pdata_ff;
        case (state_ff)
            ST_READ: begin
                // Under full security with no mask released, commands are refused.
                if (cmd_wr_i && is_cyc(cmd_addr_i, cmd_data_i, CMD_ADDR_A, CD_AA)
                    && !(sec_active && (&mask_ff))) begin
                    nxt_state = ST_C1; // [R15] [R22]
                end
            end
            ST_C1: begin
                if (cmd_wr_i) begin
                    nxt_state = is_cyc(cmd_addr_i, cmd_data_i, CMD_ADDR_B, CD_55) ?
                                ST_C2 : ST_READ; // [R23]
                end
            end
            ST_C2: begin
                if (cmd_wr_i) begin
                    if (is_cyc(cmd_addr_i, cmd_data_i, CMD_ADDR_A, CD_PROG)) begin
                        nxt_state = ST_PAGE;
                        nxt_wcnt  = 2'h0;
                    end else if (is_cyc(cmd_addr_i, cmd_data_i, CMD_ADDR_A, CD_ERASE)) begin
                        nxt_state = ST_E3;
                    end else begin
                        nxt_state = ST_READ; // [R23]
                    end
                end
            end
            ST_PAGE: begin
                if (cmd_wr_i) begin
                    if ((wcnt_ff == 2'h0) ? eff_prot[cblk] : (cblk != blk_ff)) begin
                        nxt_state = ST_READ; // [R4] [R23]
                    end else begin
                        nxt_blk   = cblk;
                        nxt_we    = 1'b1; // [R12]
                        nxt_paddr = cmd_addr_i;
                        nxt_pdata = cmd_data_i;
                        nxt_wcnt  = wcnt_ff + 2'h1;
                        if (wcnt_ff == PAGE_LAST) begin
                            nxt_state  = ST_BUSY; // [R11]
                            nxt_start  = 1'b1;
                            nxt_kind   = OP_PROG;
                            nxt_blocks = 4'h1 << cblk;
                            nxt_rdy    = 1'b0; // [R20]
                        end
                    end
                end
            end
            ST_E3: begin
                if (cmd_wr_i) begin
                    nxt_state = is_cyc(cmd_addr_i, cmd_data_i, CMD_ADDR_A, CD_AA) ?
                                ST_E4 : ST_READ; // [R23]
                end
            end
            ST_E4: begin
                if (cmd_wr_i) begin
                    nxt_state = is_cyc(cmd_addr_i, cmd_data_i, CMD_ADDR_B, CD_55) ?
                                ST_E5 : ST_READ; // [R23]
                end
            end
            ST_E5: begin
                if (cmd_wr_i) begin
                    nxt_state = ST_READ;
                    // Chip erase skips protected blocks and is barred while any mask bit is released.
                    if (is_cyc(cmd_addr_i, cmd_data_i, CMD_ADDR_A, CD_CHIP)
                        && (&mask_ff) && !sec_active && (eff_prot != 4'hF)) begin
                        nxt_state  = ST_BUSY; // [R12]
                        nxt_start  = 1'b1;
                        nxt_kind   = OP_CHIP;
                        nxt_blocks = ~eff_prot; // [R4]
                        nxt_rdy    = 1'b0;
                    end else if ((cmd_data_i == {24'h000000, CD_BLOCK}) && !eff_prot[cblk]) begin
                        nxt_state  = ST_BUSY; // [R12] [R4]
                        nxt_start  = 1'b1;
                        nxt_kind   = OP_BLOCK;
                        nxt_blocks = 4'h1 << cblk;
                        nxt_rdy    = 1'b0;
                    end
                end
            end
            ST_BUSY: begin
                // Command stores are ignored until the operation ends.
                if (op_fail_i) begin
                    nxt_state = ST_LOCK; // [R20]
                end else if (op_done_i) begin
                    nxt_state = ST_READ; // [R15]
                    nxt_rdy   = 1'b1;    // [R20]
                end
            end
            ST_LOCK: begin
                if (cmd_wr_i && (cmd_data_i == {24'h000000, CD_RESET})) begin
                    nxt_state = ST_READ; // [R17]
                end
            end
            default: nxt_state = ST_READ;
        endcase
    end

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_ff  <= ST_READ; // [R14] [R17]
            wcnt_ff   <= 2'h0;
            blk_ff    <= 2'h0;
            rdy_ff    <= 1'b1;
            start_ff  <= 1'b0;
            kind_ff   <= OP_PROG;
            blocks_ff <= 4'h0;
            we_ff     <= 1'b0;
            paddr_ff  <= 16'h0000;
            pdata_ff  <= 32'h00000000;
            rmode_ff  <= 1'b1;
        end else begin
            state_ff  <= nxt_state;
            wcnt_ff   <= nxt_wcnt;
            blk_ff    <= nxt_blk;
            rdy_ff    <= nxt_rdy;
            start_ff  <= nxt_start;
            kind_ff   <= nxt_kind;
            blocks_ff <= nxt_blocks;
            we_ff     <= nxt_we;
            paddr_ff  <= nxt_paddr;
            pdata_ff  <= nxt_pdata;
            rmode_ff  <= (nxt_state != ST_BUSY) && (nxt_state != ST_LOCK); // [R14] [R16]
        end
    end

    assign avs_waitrequest_o = wait_ff;
    assign avs_readdata_o    = rdata_ff;
    assign read_mode_o       = rmode_ff;
    assign ready_busy_flag_o = rdy_ff;
    assign op_start_o        = start_ff;
    assign op_kind_o         = kind_ff;
    assign op_blocks_o       = blocks_ff;
    assign prog_we_o         = we_ff;
    assign prog_addr_o       = paddr_ff;
    assign prog_data_o       = pdata_ff;

    // ==========================================================================
    // Checks
    chk_mask_reset: assert property (@(posedge mclk_i) disable iff (!resetn_i) // [R7]
        $rose(resetn_i) |-> (mask_ff == MASK_RST))
        else $error("Mask not all ones after system reset.");

    chk_sec_holds: assert property (@(posedge mclk_i) disable iff (!power_on_resetn_i) // [R2]
        !resetn_i |=> (sec_ff == $past(sec_ff)))
        else $error("Security bit changed under system reset.");

    chk_status_track: assert property (@(posedge mclk_i) disable iff (!resetn_i) // [R5]
        $past(resetn_i) |-> (pstat_ff == $past(nv_protect_i)))
        else $error("Protect status does not follow the stored state.");

    chk_upper_zero: assert property (@(posedge mclk_i) disable iff (!resetn_i) // [R19]
        !avs_waitrequest_o |-> (avs_readdata_o[31:4] == 28'h0000000))
        else $error("Unused register bits read nonzero.");

    chk_prot_refuse: assert property (@(posedge mclk_i) disable iff (!resetn_i) // [R4]
        op_start_o |-> ((op_blocks_o & pstat_ff & mask_ff) == 4'h0))
        else $error("Operation started on a protected block.");

    chk_busy_noread: assert property (@(posedge mclk_i) disable iff (!resetn_i) // [R16]
        (state_ff == ST_BUSY) |-> (!read_mode_o && !ready_busy_flag_o))
        else $error("Read mode or ready shown during automatic operation.");

    chk_done_return: assert property (@(posedge mclk_i) disable iff (!resetn_i) // [R15]
        (state_ff == ST_BUSY && op_done_i && !op_fail_i) |=> (ready_busy_flag_o && read_mode_o))
        else $error("Normal completion did not return to read mode.");

    chk_fail_hold: assert property (@(posedge mclk_i) disable iff (!resetn_i) // [R20]
        (state_ff == ST_BUSY && op_fail_i) |=> !ready_busy_flag_o [*2])
        else $error("Ready flag rose after a failed operation.");

    chk_seq_abandon: assert property (@(posedge mclk_i) disable iff (!resetn_i) // [R23]
        (state_ff == ST_C1 && cmd_wr_i && !is_cyc(cmd_addr_i, cmd_data_i, CMD_ADDR_B, CD_55))
        |=> (state_ff == ST_READ))
        else $error("Out-of-order command cycle not abandoned.");

    chk_secure_refuse: assert property (@(posedge mclk_i) disable iff (!resetn_i) // [R22]
        (state_ff == ST_READ && sec_ff && (&pstat_ff) && (&mask_ff)) |=> (state_ff == ST_READ))
        else $error("Command accepted under active security.");

endmodule
`default_nettype wire

// >>> verif/flash_macro_model.sv
// Behavioural flash macro that answers each started operation after a delay.
`timescale 1ns/100ps
`default_nettype none
module flash_macro_model #(
    parameter int DELAY = 20
) (
    input  wire logic clk_i,
    input  wire logic rstn_i,
    input  wire logic start_i,
    input  wire logic fail_mode_i,
    output logic      done_o,
    output logic      fail_o
);
    int cnt;
    // ==========================================================================
    // Operation timer
    // Once started the operation runs on its own; no further stores are needed.
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt <= 0;
            done_o <= 1'b0;
            fail_o <= 1'b0;
        end else begin
            done_o <= (cnt == 1) && !fail_mode_i;
            fail_o <= (cnt == 1) && fail_mode_i;
            if (start_i === 1'b1) cnt <= DELAY;
            else if (cnt > 0) cnt <= cnt - 1;
        end
    end
endmodule
`default_nettype wire

// >>> verif/test_flash_protect_and_mode_control.sv
// Self-checking bench for the flash protect and mode controller.
`timescale 1ns/100ps
`default_nettype none
module test_flash_protect_and_mode_control;
    import flash_ctl_pkg::*;
    logic        clk = 1'b0, rstn = 1'b0, por_n = 1'b0, rd = 1'b0, wr = 1'b0;
    logic        cwr = 1'b0, fmode = 1'b0, waitr, rmode, rdy, start, pwe, done, fail;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0, cdata = 32'h0, rdata, pdata, pd_c;
    logic [15:0] caddr = 16'h0, paddr, pa_c;
    logic [3:0]  nv = 4'h2, be = 4'hF, blocks, blk_c;
    op_kind_t    kind, kind_c;
    int          n_fail = 0, n_tests = 0, n_start = 0, n_we = 0;
    always #2.5 clk = ~clk;
    flash_protect_and_mode_control flash_protect_and_mode_control_i (
        .mclk_i(clk), .resetn_i(rstn), .power_on_resetn_i(por_n),
        .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr),
        .avs_writedata_i(wdata), .avs_byteenable_i(be),
        .avs_readdata_o(rdata), .avs_waitrequest_o(waitr),
        .cmd_wr_i(cwr), .cmd_addr_i(caddr), .cmd_data_i(cdata),
        .nv_protect_i(nv), .op_done_i(done), .op_fail_i(fail),
        .read_mode_o(rmode), .ready_busy_flag_o(rdy), .op_start_o(start),
        .op_kind_o(kind), .op_blocks_o(blocks), .prog_we_o(pwe),
        .prog_addr_o(paddr), .prog_data_o(pdata));
    flash_macro_model #(.DELAY(20)) flash_macro_model_i (
        .clk_i(clk), .rstn_i(rstn), .start_i(start), .fail_mode_i(fmode),
        .done_o(done), .fail_o(fail));
    always @(posedge clk) begin
        if (start === 1'b1) begin
            n_start <= n_start + 1;
            kind_c <= kind;
            blk_c <= blocks;
        end
        if (pwe === 1'b1) begin
            n_we <= n_we + 1;
            pa_c <= paddr;
            pd_c <= pdata;
        end
    end
    // ==========================================================================
    // Shared tasks
    task automatic finish_test();
        if (n_fail == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk);
        wr <= w;
        rd <= ~w;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        while (waitr !== 1'b0 && n < 50) begin
            @(posedge clk);
            n++;
        end
        if (n >= 50) n_fail++;
        q = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(q, e);
    endtask
    task automatic keyw(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, UNLOCK_KEY, q);
        bus(1'b1, a, d, q);
    endtask
    task automatic cmd(input logic [15:0] a, input logic [31:0] d);
        @(posedge clk);
        cwr <= 1'b1;
        caddr <= a;
        cdata <= d;
        @(posedge clk);
        cwr <= 1'b0;
    endtask
    task automatic two();
        cmd(CMD_ADDR_A, 32'(CD_AA));
        cmd(CMD_ADDR_B, 32'(CD_55));
    endtask
    task automatic erase(input logic [15:0] a, input logic [7:0] c);
        two();
        cmd(CMD_ADDR_A, 32'(CD_ERASE));
        two();
        cmd(a, 32'(c));
    endtask
    task automatic expect_op(input int s0, input logic go);
        int n;
        n = 0;
        repeat (3) @(posedge clk);
        chk(32'(n_start - s0), 32'(go));
        if (go) begin
            chk({31'h0, rmode}, 32'h0);
            rchk(FSTAT_OFS, 32'h0);
            // The bench never reads the array after ready, so the settling wait holds.
            while (rdy !== 1'b1 && n < 200) begin
                @(posedge clk);
                n++;
            end
            chk({31'h0, rmode}, 32'h1);
        end else begin
            chk({31'h0, rmode}, 32'h1);
        end
    endtask
    // ==========================================================================
    // Scenarios
    task automatic t_reset();
        chk({31'h0, rmode}, 32'h1);
        rchk(SEC_OFS, 32'h1);
        rchk(FSTAT_OFS, 32'h1);
        rchk(PSTAT_OFS, 32'h2);
        rchk(PMASK_OFS, 32'hF);
        rchk(8'h00, 32'h0);
    endtask
    task automatic t_regs();
        logic [31:0] q;
        bus(1'b1, PMASK_OFS, 32'h5, q);
        rchk(PMASK_OFS, 32'hF);
        bus(1'b1, PMASK_OFS, UNLOCK_KEY, q);
        repeat (14) @(posedge clk);
        bus(1'b1, PMASK_OFS, 32'h5, q);
        rchk(PMASK_OFS, 32'hF);
        be <= 4'h1;
        keyw(PMASK_OFS, 32'h5);
        be <= 4'hF;
        rchk(PMASK_OFS, 32'hF);
        keyw(PMASK_OFS, 32'hFFFF_FFF5);
        rchk(PMASK_OFS, 32'h5);
        bus(1'b1, PSTAT_OFS, 32'h0, q);
        nv <= 4'h9;
        rchk(PSTAT_OFS, 32'h9);
        nv <= 4'h2;
        keyw(PMASK_OFS, 32'hF);
        nv <= 4'hF;
        erase(16'h4000, CD_BLOCK);
        expect_op(n_start, 1'b0);
        nv <= 4'h2;
    endtask
    task automatic t_erase();
        int s;
        s = n_start;
        erase(16'h4000, CD_BLOCK);
        expect_op(s, 1'b0);
        keyw(PMASK_OFS, 32'hD);
        rchk(PMASK_OFS, 32'hD);
        s = n_start;
        erase(16'h4000, CD_BLOCK);
        expect_op(s, 1'b1);
        chk(32'(kind_c), 32'(OP_BLOCK));
        chk(32'(blk_c), 32'h2);
        s = n_start;
        erase(CMD_ADDR_A, CD_CHIP);
        expect_op(s, 1'b0);
        keyw(PMASK_OFS, 32'hF);
        s = n_start;
        erase(CMD_ADDR_A, CD_CHIP);
        expect_op(s, 1'b1);
        chk(32'(kind_c), 32'(OP_CHIP));
    endtask
    task automatic t_prog();
        int s, w;
        s = n_start;
        w = n_we;
        two();
        cmd(CMD_ADDR_A, 32'(CD_PROG));
        for (int i = 0; i < 4; i++) begin
            cmd(16'(i * 4), 32'h1234_5670 + i);
        end
        expect_op(s, 1'b1);
        chk(32'(n_we - w), 32'h4);
        chk({16'h0, pa_c}, 32'hC);
        chk(pd_c, 32'h1234_5673);
        chk(32'(blk_c), 32'h1);
        s = n_start;
        w = n_we;
        two();
        cmd(CMD_ADDR_A, 32'(CD_PROG));
        cmd(16'h4000, 32'h0);
        expect_op(s, 1'b0);
        chk(32'(n_we - w), 32'h0);
    endtask
    task automatic t_fail();
        int s;
        fmode <= 1'b1;
        erase(16'h0000, CD_BLOCK);
        repeat (40) @(posedge clk);
        chk({30'h0, rdy, rmode}, 32'h0);
        cmd(CMD_ADDR_A, 32'(CD_RESET));
        repeat (2) @(posedge clk);
        chk({30'h0, rdy, rmode}, 32'h1);
        fmode <= 1'b0;
        keyw(SEC_OFS, 32'h0);
        rchk(SEC_OFS, 32'h0);
        keyw(PMASK_OFS, 32'h7);
        @(posedge clk);
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        rchk(FSTAT_OFS, 32'h1);
        rchk(SEC_OFS, 32'h0);
        rchk(PMASK_OFS, 32'hF);
        s = n_start;
        two();
        cmd(CMD_ADDR_A, 32'(CD_ERASE));
        cmd(CMD_ADDR_B, 32'(CD_55));
        two();
        cmd(16'h0000, 32'(CD_BLOCK));
        cmd(CMD_ADDR_A, 32'(CD_AA));
        cmd(CMD_ADDR_A, 32'(CD_AA));
        expect_op(s, 1'b0);
    endtask
    // ==========================================================================
    // Main sequence and watchdog
    initial begin
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        por_n <= 1'b1;
        // No interrupt or fault is raised while a command runs.
        t_reset();
        t_regs();
        t_erase();
        t_prog();
        t_fail();
        finish_test();
    end
    initial begin
        #100000;
        n_fail++;
        finish_test();
    end
endmodule
`default_nettype wire
